// *** core/down_count_timer_pwm.sv ***
// design: 16-bit down-count timer/counter/pwm with ahb-lite register slave
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/100ps

// Notes on behaviour
// - sixteen-bit counter, down count only
// - software selects the counting clock source
// - five selectable compare relations drive pwm
// - period reloads on start, reset, terminal count
// - free running, single pass, enable gated
// - single pass halts at terminal count
// - gated mode counts only while enabled
// - compare, terminal count, complementary outputs
// - deadband keeps true and complement apart
// - kill forces compare outputs inactive
// - reset restarts count, capture latches count
module down_count_timer_pwm (
  input  wire logic        clock,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // routed inputs, asynchronous to clock
  input  wire logic        restart_in,
  input  wire logic        capture_in,
  input  wire logic        kill_in,
  input  wire logic        enable_in,
  input  wire logic        ext_clk_in,
  // routed outputs
  output logic             cmp_out,
  output logic             cmp_n_out,
  output logic             tc_out
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers

  logic               rst_s1_r;     // first reset stage
  logic               rst_n_r;      // synchronised reset used everywhere
  tmr_pkg::routed_t   sync1_r;      // first stage, read only by second stage
  tmr_pkg::routed_t   sync2_r;      // usable copies of routed inputs
  logic               ext_clk_d_r;  // previous external clock level
  logic               restart_d_r;  // previous restart level
  logic               capture_d_r;  // previous capture level

  // asynchronous assert, synchronous release
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // two flops on every routed input before any logic looks at it
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= '{restart: restart_in, capture: capture_in, kill: kill_in,
                   enable: enable_in, ext_clk: ext_clk_in};
      sync2_r <= sync1_r;
    end
  end

  // edge history, taken from the second stage only
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ext_clk_d_r <= 1'b0;
      restart_d_r <= 1'b0;
      capture_d_r <= 1'b0;
    end else begin
      ext_clk_d_r <= sync2_r.ext_clk;
      restart_d_r <= sync2_r.restart;
      capture_d_r <= sync2_r.capture;
    end
  end

  // edge history resets low, the idle level of the pins, so no false edge follows reset
  logic restart_rise;  // one-cycle restart event
  logic capture_rise;  // one-cycle capture event
  assign restart_rise = sync2_r.restart & ~restart_d_r;
  assign capture_rise = sync2_r.capture & ~capture_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave and registers

  logic [31:0]             ctrl_r;     // control word
  logic [15:0]             period_r;   // reload value
  logic [15:0]             compare_r;  // pwm compare value
  logic [7:0]              dead_r;     // deadband in clock cycles
  logic [15:0]             capture_r;  // last captured count
  logic                    cap_flag_r; // capture happened, write one to clear
  logic                    wr_pend_r;  // write data phase pending
  logic                    rd_pend_r;  // read data phase pending
  logic [tmr_pkg::ADDR_W-1:0] addr_r;  // latched address of data phase
  logic                    start_pulse; // software wrote start as one
  tmr_pkg::ctrl_t          cfg;        // decoded control fields

  // control field decode
  // control fields are decoded once here so every process sees one view
  assign cfg = '{comp_en: ctrl_r[tmr_pkg::CTRL_COMP_BIT],
                 clk_sel: tmr_pkg::clk_sel_t'(ctrl_r[tmr_pkg::CTRL_CLK_LSB +: 2]),
                 cmp_mode: tmr_pkg::cmp_mode_t'(ctrl_r[tmr_pkg::CTRL_CMP_LSB +: 3]),
                 run_mode: tmr_pkg::run_mode_t'(ctrl_r[tmr_pkg::CTRL_MODE_LSB +: 2]),
                 start: ctrl_r[tmr_pkg::CTRL_START_BIT]};

  // address phase capture; zero wait states so hreadyout stays high
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= '0;
    end else if (hready) begin
      wr_pend_r <= hsel & htrans[1] & hwrite;
      rd_pend_r <= hsel & htrans[1] & ~hwrite;
      addr_r    <= haddr[tmr_pkg::ADDR_W-1:0];
    end
  end

  // responses: always okay, never stalled
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // start acts on every write of one to the start bit, running or not,
  // so software can re-arm a running count without stopping it first
  assign start_pulse = wr_pend_r && (addr_r == tmr_pkg::ADDR_CTRL) &&
                       hwdata[tmr_pkg::CTRL_START_BIT];

  // register writes during the data phase
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r    <= '0;
      period_r  <= tmr_pkg::PERIOD_RST;
      compare_r <= tmr_pkg::COMPARE_RST;
      dead_r    <= tmr_pkg::DEAD_RST;
    end else if (wr_pend_r) begin
      case (addr_r)
        tmr_pkg::ADDR_CTRL:    ctrl_r    <= {23'h000000, hwdata[8:0]};
        tmr_pkg::ADDR_PERIOD:  period_r  <= hwdata[15:0];
        tmr_pkg::ADDR_COMPARE: compare_r <= hwdata[15:0];
        tmr_pkg::ADDR_DEAD:    dead_r    <= hwdata[7:0];
        default:               ctrl_r    <= ctrl_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter clock selection

  logic [2:0] pre_r;   // free prescaler for the divided sources
  logic       tick;    // one counter clock edge this cycle

  // shared prescaler: the phase of a divided tick after start is arbitrary
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_r + 3'h1;
    end
  end

  always_comb begin
    case (cfg.clk_sel)
      tmr_pkg::clk_every: tick = 1'b1;
      tmr_pkg::clk_div2:  tick = pre_r[0];
      tmr_pkg::clk_div8:  tick = (pre_r == 3'h7);
      tmr_pkg::clk_ext:   tick = sync2_r.ext_clk & ~ext_clk_d_r;
      default:            tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter state machine

  // done is kept apart from idle so software can tell a finished single pass
  typedef enum logic [1:0] {st_idle, st_run, st_done} cnt_state_t;
  cnt_state_t  state_r;   // idle, counting or finished single pass
  logic [15:0] count_r;   // the down counter
  logic        tc_r;      // terminal count pulse
  logic        step;      // counter decrements this cycle

  assign step = (state_r == st_run) && tick &&
                ((cfg.run_mode != tmr_pkg::mode_gated) || sync2_r.enable);

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= st_idle;
      count_r <= tmr_pkg::PERIOD_RST;
    end else if (start_pulse || restart_rise) begin
      state_r <= st_run;
      count_r <= period_r;
    end else if (wr_pend_r && addr_r == tmr_pkg::ADDR_CTRL && !hwdata[tmr_pkg::CTRL_START_BIT]) begin
      // software stop parks the count where it stands
      state_r <= st_idle;
    end else if (step) begin
      if (count_r == 16'h0000) begin
        count_r <= period_r;
        if (cfg.run_mode == tmr_pkg::mode_oneshot) begin
          state_r <= st_done;
        end
      end else begin
        count_r <= count_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tc_r <= 1'b0;
    end else if (start_pulse || restart_rise) begin
      // a reload on the edge of the last step must not leave a stale pulse
      tc_r <= 1'b0;
    end else if (step) begin
      // set as the count steps from one to zero
      tc_r <= (count_r == 16'h0001);
    end else if (tick) begin
      tc_r <= 1'b0;
    end
  end

  // capture latch, set wins over clear
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      capture_r  <= 16'h0000;
      cap_flag_r <= 1'b0;
    end else if (capture_rise) begin
      capture_r  <= count_r;
      cap_flag_r <= 1'b1;
    end else if (wr_pend_r && addr_r == tmr_pkg::ADDR_STATUS && hwdata[tmr_pkg::STAT_CAP_BIT]) begin
      // clear only when no capture lands in the same cycle
      cap_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, deadband and kill

  function automatic logic compare_hit(input tmr_pkg::cmp_mode_t m,
                                       input logic [15:0] c, input logic [15:0] v);
    case (m)
      tmr_pkg::cmp_less:             compare_hit = c < v;
      tmr_pkg::cmp_less_or_equal:    compare_hit = c <= v;
      tmr_pkg::cmp_equal:            compare_hit = c == v;
      tmr_pkg::cmp_greater_or_equal: compare_hit = c >= v;
      tmr_pkg::cmp_greater:          compare_hit = c > v;
      default:                       compare_hit = 1'b0;
    endcase
  endfunction : compare_hit

  logic       pwm_r;    // raw compare result, registered
  logic [7:0] dead_cnt_r; // cycles since last raw edge
  logic       cmp_r;    // output flop
  logic       cmp_n_r;  // complementary output flop

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pwm_r <= 1'b0;
    end else begin
      // a parked or finished timer shows an inactive raw compare
      pwm_r <= (state_r == st_run) && compare_hit(cfg.cmp_mode, count_r, compare_r);
    end
  end

  // deadband counter restarts on each raw edge
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dead_cnt_r <= 8'h00;
    end else if (pwm_r != ((state_r == st_run) && compare_hit(cfg.cmp_mode, count_r, compare_r))) begin
      dead_cnt_r <= 8'h00;
    end else if (dead_cnt_r != 8'hFF) begin
      dead_cnt_r <= dead_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cmp_r   <= 1'b0;
      cmp_n_r <= 1'b0;
      tc_out  <= 1'b0;
    end else begin
      tc_out  <= tc_r;
      if (sync2_r.kill) begin
        cmp_r   <= 1'b0;
        cmp_n_r <= 1'b0;
      end else if (!cfg.comp_en) begin
        cmp_r   <= pwm_r;
        cmp_n_r <= 1'b0;
      end else begin
        // each side waits out the deadband after an edge
        cmp_r   <= pwm_r & (dead_cnt_r >= dead_r);
        cmp_n_r <= ~pwm_r & (dead_cnt_r >= dead_r);
      end
    end
  end

  // the pwm pins come straight from their output flops
  assign cmp_out   = cmp_r;
  assign cmp_n_out = cmp_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // read data

  // live count read, no side effect
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[tmr_pkg::ADDR_W-1:0])
        tmr_pkg::ADDR_CTRL:    hrdata <= ctrl_r;
        tmr_pkg::ADDR_PERIOD:  hrdata <= {16'h0000, period_r};
        tmr_pkg::ADDR_COMPARE: hrdata <= {16'h0000, compare_r};
        tmr_pkg::ADDR_DEAD:    hrdata <= {24'h000000, dead_r};
        tmr_pkg::ADDR_COUNT:   hrdata <= {16'h0000, count_r};
        tmr_pkg::ADDR_CAPTURE: hrdata <= {16'h0000, capture_r};
        tmr_pkg::ADDR_STATUS:  hrdata <= {28'h0000000, sync2_r.kill, state_r == st_done,
                                          state_r == st_run, cap_flag_r};
        default:               hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule : down_count_timer_pwm

// *** core/tmr_pkg.sv ***
// package: register map, field layouts and carrier types of the down-count timer/pwm
package tmr_pkg;

  // register byte offsets (one aligned word each)
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PERIOD  = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_DEAD    = 8'h0C;
  localparam logic [7:0] ADDR_COUNT   = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;

  // control field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int CTRL_CMP_LSB   = 3;
  localparam int CTRL_CLK_LSB   = 6;
  localparam int CTRL_COMP_BIT  = 8;

  // status field written as one to clear the capture flag
  localparam int STAT_CAP_BIT   = 0;

  // reset values
  localparam logic [15:0] PERIOD_RST  = 16'hFFFF;
  localparam logic [15:0] COMPARE_RST = 16'h8000;
  localparam logic [7:0]  DEAD_RST    = 8'h00;

  // counter width and address decode width
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 8;

  // run modes
  typedef enum logic [1:0] {
    mode_free    = 2'h0,
    mode_oneshot = 2'h1,
    mode_gated   = 2'h2
  } run_mode_t;

  // compare relations
  typedef enum logic [2:0] {
    cmp_less             = 3'h0,
    cmp_less_or_equal    = 3'h1,
    cmp_equal            = 3'h2,
    cmp_greater_or_equal = 3'h3,
    cmp_greater          = 3'h4
  } cmp_mode_t;

  // clock source choices
  typedef enum logic [1:0] {
    clk_every = 2'h0,
    clk_div2  = 2'h1,
    clk_div8  = 2'h2,
    clk_ext   = 2'h3
  } clk_sel_t;

  // configuration bundle decoded from the control register
  typedef struct packed {
    logic      comp_en;
    clk_sel_t  clk_sel;
    cmp_mode_t cmp_mode;
    run_mode_t run_mode;
    logic      start;
  } ctrl_t;

  // routed inputs after synchronisation
  typedef struct packed {
    logic restart;
    logic capture;
    logic kill;
    logic enable;
    logic ext_clk;
  } routed_t;

endpackage : tmr_pkg

// *** sim/tmr_monitor.sv ***
// checker: bus answers and output relations of the down-count timer/pwm
`timescale 1ns/100ps
module tmr_monitor (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        kill_in,
  input wire logic        cmp_out,
  input wire logic        cmp_n_out,
  input wire logic        tc_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // read address phase taken by the slave
  logic rd;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  //////////////////////////////////////////////////////////////////////
  AST_HRESP_OKAY: assert property (hresp == 1'b0) else $error("hresp not okay");
  // slave ready a few edges after the synced reset release
  AST_READY_UP: assert property (reset_n [*5] |-> hreadyout) else $error("hreadyout low");
  AST_NO_OVERLAP: assert property (!(cmp_out && cmp_n_out)) else $error("outputs overlap");
  // kill needs the two sync flops plus the output flop to land
  AST_KILL_QUIET: assert property (kill_in [*5] |-> !cmp_out && !cmp_n_out) else $error("kill ignored");
  AST_UNMAPPED_ZERO: assert property (rd && haddr[7:0] == 8'h1C |=> hrdata == 32'h0) else $error("unmapped data");
  AST_UPPER_ZERO: assert property (rd |=> hrdata[31:16] == 16'h0000) else $error("upper bits set");
  AST_HOLD_DATA: assert property (!rd |=> $stable(hrdata)) else $error("hrdata moved");
  AST_STATUS_BITS: assert property (rd && haddr[7:0] == 8'h18 |=> hrdata[31:4] == 28'h0) else $error("status bits");
  //////////////////////////////////////////////////////////////////////
  COV_KILL: cover property (kill_in [*5]);
  COV_TC: cover property ($rose(tc_out));
  COV_COMP: cover property ($rose(cmp_n_out));
endmodule : tmr_monitor
bind down_count_timer_pwm tmr_monitor tmr_monitor_inst (.clock(clock), .reset_n(reset_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .kill_in(kill_in), .cmp_out(cmp_out), .cmp_n_out(cmp_n_out), .tc_out(tc_out));

// *** sim/routed_far_end.sv ***
// far-side model: routed control pins that feed the timer/pwm
`timescale 1ns/100ps
module routed_far_end (
  input  wire logic        clock,
  output tmr_pkg::routed_t pins
);
  // all pins rest low; the external count clock stands still between bursts
  initial pins = '0;
  task put(input tmr_pkg::routed_t v);
    pins <= v;
  endtask : put
  // hold any pin pattern for n clocks, then back to rest
  task drive(input tmr_pkg::routed_t v, input int n);
    pins <= v;
    repeat (n) @(posedge clock);
    pins <= '0;
  endtask : drive
  // slow edges so the two-flop sync sees every one
  task ext_edges(input int n);
    repeat (n) begin
      drive(tmr_pkg::routed_t'(5'h01), 4);
      repeat (4) @(posedge clock);
    end
  endtask : ext_edges
endmodule : routed_far_end

// *** sim/test_down_count_timer_pwm.sv ***
// testbench: bus, counting, compare, deadband and kill scenarios of the timer/pwm
`timescale 1ns/100ps
module test_down_count_timer_pwm;
  logic             clock = 1'b0;
  logic             reset_n = 1'b0;
  logic             hsel = 1'b0;
  logic      [31:0] haddr = 32'h0;
  logic      [1:0]  htrans = 2'h0;
  logic      [2:0]  hsize = 3'h0;
  logic             hwrite = 1'b0;
  logic      [31:0] hwdata = 32'h0;
  logic      [31:0] hrdata;
  logic             hreadyout, hresp, cmp_out, cmp_n_out, tc_out;
  tmr_pkg::routed_t pins;
  logic      [31:0] q, p, v;
  int               bad_count = 0, total_checks = 0, seed = 32'hae99, k, j, n;
  int               dv[3] = '{1, 2, 8};
  down_count_timer_pwm down_count_timer_pwm_inst (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .restart_in(pins.restart), .capture_in(pins.capture),
    .kill_in(pins.kill), .enable_in(pins.enable), .ext_clk_in(pins.ext_clk), .cmp_out(cmp_out),
    .cmp_n_out(cmp_n_out), .tc_out(tc_out));
  routed_far_end routed_far_end_inst (.clock(clock), .pins(pins));
  initial forever #2 clock = ~clock;
  //////////////////////////////////////////////////////////////////////
  // one ahb-lite single transfer; waits on hready, no fixed latency assumed
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask : bus
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rchk
  // cycles from one terminal count rise to the next, sampled on falling edges
  task gap(output int m);
    int i;
    m = 0;
    @(negedge clock);
    for (i = 0; i < 3000 && tc_out !== 1'b0; i++) @(negedge clock);
    for (i = 0; i < 3000 && tc_out !== 1'b1; i++) @(negedge clock);
    for (i = 0; i < 3000 && tc_out !== 1'b0; i++) begin
      @(negedge clock);
      m++;
    end
    for (i = 0; i < 3000 && tc_out !== 1'b1; i++) begin
      @(negedge clock);
      m++;
    end
    @(posedge clock);
  endtask : gap
  function logic [31:0] ctl(input logic [1:0] md, input logic [2:0] cm, input logic [1:0] ck, input logic ce);
    return {23'h0, ce, ck, cm, md, 1'b1};
  endfunction : ctl
  function logic rel(input int m, input logic [15:0] c, input logic [15:0] w);
    case (m)
      0: return c < w;
      1: return c <= w;
      2: return c == w;
      3: return c >= w;
      default: return c > w;
    endcase
  endfunction : rel
  task close_out;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    // register reset values and an unmapped word
    rchk(tmr_pkg::ADDR_PERIOD, 32'h0000FFFF);
    rchk(tmr_pkg::ADDR_COMPARE, 32'h00008000);
    rchk(tmr_pkg::ADDR_DEAD, 32'h00000000);
    rchk(8'h1C, 32'h00000000);
    p = 32'h4 + ($random(seed) & 32'h7);
    bus(1'b1, tmr_pkg::ADDR_PERIOD, p);
    // free run: terminal count every period+1 ticks of each internal source
    for (k = 0; k < 3; k++) begin
      bus(1'b1, tmr_pkg::ADDR_CTRL, ctl(2'h0, 3'h0, 2'(k), 1'b0));
      gap(n);
      chk(n, (p + 1) * dv[k]);
    end
    bus(1'b1, tmr_pkg::ADDR_CTRL, ctl(2'h0, 3'h0, 2'h3, 1'b0));
    routed_far_end_inst.ext_edges(3);
    repeat (6) @(posedge clock);
    rchk(tmr_pkg::ADDR_COUNT, p - 3);
    // single pass halts reloaded with done set
    bus(1'b1, tmr_pkg::ADDR_CTRL, ctl(2'h1, 3'h0, 2'h0, 1'b0));
    repeat (40) @(posedge clock);
    rchk(tmr_pkg::ADDR_STATUS, 32'h4);
    rchk(tmr_pkg::ADDR_COUNT, p);
    // a write of zero parks the timer; control reads back as written
    bus(1'b1, tmr_pkg::ADDR_CTRL, 32'h0);
    rchk(tmr_pkg::ADDR_CTRL, 32'h0);
    rchk(tmr_pkg::ADDR_STATUS, 32'h0);
    // gated counting, capture and restart
    p = 32'h100 + ($random(seed) & 32'hFFF);
    n = 3 + ($random(seed) & 15);
    bus(1'b1, tmr_pkg::ADDR_PERIOD, p);
    bus(1'b1, tmr_pkg::ADDR_CTRL, ctl(2'h2, 3'h0, 2'h0, 1'b0));
    rchk(tmr_pkg::ADDR_COUNT, p);
    routed_far_end_inst.drive(tmr_pkg::routed_t'(5'h02), n);
    repeat (6) @(posedge clock);
    rchk(tmr_pkg::ADDR_COUNT, p - n);
    rchk(tmr_pkg::ADDR_COUNT, p - n);
    routed_far_end_inst.drive(tmr_pkg::routed_t'(5'h08), 2);
    repeat (6) @(posedge clock);
    rchk(tmr_pkg::ADDR_CAPTURE, p - n);
    rchk(tmr_pkg::ADDR_STATUS, 32'h3);
    bus(1'b1, tmr_pkg::ADDR_STATUS, 32'h1);
    rchk(tmr_pkg::ADDR_STATUS, 32'h2);
    routed_far_end_inst.drive(tmr_pkg::routed_t'(5'h10), 2);
    repeat (6) @(posedge clock);
    rchk(tmr_pkg::ADDR_COUNT, p);
    // every relation around the held count, complement enabled
    for (k = 0; k < 5; k++) begin
      for (j = 0; j < 3; j++) begin
        v = p - 1 + j;
        bus(1'b1, tmr_pkg::ADDR_COMPARE, v);
        bus(1'b1, tmr_pkg::ADDR_CTRL, ctl(2'h2, 3'(k), 2'h0, 1'b1));
        repeat (8) @(posedge clock);
        chk(cmp_out, rel(k, p[15:0], v[15:0]));
        chk(cmp_n_out, !rel(k, p[15:0], v[15:0]));
      end
    end
    // deadband: both outputs low for exactly the programmed span
    v = 32'h4 + ($random(seed) & 32'h7);
    bus(1'b1, tmr_pkg::ADDR_DEAD, v);
    bus(1'b1, tmr_pkg::ADDR_CTRL, ctl(2'h2, 3'h1, 2'h0, 1'b1));
    n = 0;
    repeat (64) begin
      @(negedge clock);
      n += (cmp_out === 1'b0 && cmp_n_out === 1'b0);
    end
    @(posedge clock);
    chk(n, v);
    chk(cmp_out, 1'b1);
    // kill forces both outputs low while held
    routed_far_end_inst.put(tmr_pkg::routed_t'(5'h04));
    repeat (8) @(posedge clock);
    chk({cmp_out, cmp_n_out}, 2'h0);
    rchk(tmr_pkg::ADDR_STATUS, 32'hA);
    routed_far_end_inst.put(tmr_pkg::routed_t'(5'h00));
    repeat (64) @(posedge clock);
    chk(cmp_out, 1'b1);
    close_out();
  end
endmodule : test_down_count_timer_pwm
